// ---- design/ucpd_detect.sv ----
// module: usb charge port type detection sequencer
// Notes on behaviour
// RULE_01 - detection starts by itself only in standalone mode
// RULE_02 - in host mode software sets the force bit to start detection
// RULE_03 - detection in host mode leaves the input current limit unapplied
// RULE_04 - limit-select pins act only after detection and a later pin change
// RULE_05 - sequencer has five primary states
// RULE_06 - vbus arrival outside host mode, or force bit, enters contact detect
// RULE_07 - contact timeout goes to non-standard test, else primary detection
// RULE_08 - primary detection picks dcp/cdp path or sdp/non-standard path
// RULE_09 - non-standard test pass goes to configure, fail to primary
// RULE_10 - secondary resolves dcp, cdp, sdp or non-standard then configures
// RULE_11 - configure sets input limit and charge timer by port type
// RULE_12 - limits: dcp external, dead 100ma, cdp 1500ma, sdp hi-z, other 500ma
// RULE_13 - timers: 6 hours, dead battery 45 minutes, good sdp none
// RULE_14 - dead battery unconnected device draws at most 100ma
// RULE_15 - d+ source driven during battery wakeup
// RULE_16 - software writing clear bit removes the d+ source; the code lets configure override a clear written in the same cycle
// RULE_17 - system connects to host within one second after clear
// RULE_18 - accessory adapters unidentified; default to 500ma
// RULE_19 - result held until next vbus arrival or force request
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ucpd_detect
#(
   parameter int DCD_CYCLES = ucpd_pkg::DCD_TIMEOUT_CYCLES
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // mode and supply
   input wire logic i_host_mode,
   input wire logic i_vbus,
   input wire logic i_batt_good,
   // line comparator results and limit-select pins
   input wire logic i_data_contact,
   input wire logic i_primary_charger,
   input wire logic i_secondary_dcp,
   input wire logic i_secondary_nonstd,
   input wire logic i_nonstd_pass,
   input wire logic i_limit_select_lo,
   input wire logic i_limit_select_hi,
   // results
   output logic o_dplus_source,
   output logic [2:0] o_current_limit,
   output logic o_limit_apply,
   output logic [1:0] o_charge_timer,
   output logic [2:0] o_port_type,
   output logic o_detect_busy
);
   localparam int TW = 25;

   typedef struct packed
   {
      ucpd_pkg::ucpd_state_type state;
      ucpd_pkg::ucpd_port_type port;
      logic dcp_path;
      logic host_run;
      logic vbus_q;
      logic done_once;
      logic [1:0] sel_q;
      logic pins_live;
      logic [2:0] limit;
      logic apply;
      logic [1:0] timer;
      logic dplus;
      logic [7:0] rdata;
      logic tmr_start;
      logic busy;
   } ucpd_st_type;
   ucpd_st_type st_reg;
   ucpd_st_type st_next;
   logic dcd_expired;

   // settings lookup by port and battery
   function automatic logic [2:0] limit_of(input ucpd_pkg::ucpd_port_type p, input logic good);
      if (p == ucpd_pkg::PT_DCP)
         limit_of = ucpd_pkg::LIM_EXTERNAL;
      else if ((p == ucpd_pkg::PT_CDP || p == ucpd_pkg::PT_SDP) && !good)
         limit_of = ucpd_pkg::LIM_100MA;
      else if (p == ucpd_pkg::PT_CDP)
         limit_of = ucpd_pkg::LIM_1500MA;
      else if (p == ucpd_pkg::PT_SDP)
         limit_of = ucpd_pkg::LIM_HIZ;
      else
         limit_of = ucpd_pkg::LIM_500MA;
   endfunction : limit_of

   function automatic logic [1:0] timer_of(input ucpd_pkg::ucpd_port_type p, input logic good);
      if ((p == ucpd_pkg::PT_CDP || p == ucpd_pkg::PT_SDP) && !good)
         timer_of = ucpd_pkg::TMR_45MIN;
      else if (p == ucpd_pkg::PT_SDP)
         timer_of = ucpd_pkg::TMR_NONE;
      else
         timer_of = ucpd_pkg::TMR_6HOUR;
   endfunction : timer_of

   function automatic logic [2:0] pin_limit(input logic [1:0] sel);
      if (sel == 2'h0)
         pin_limit = ucpd_pkg::LIM_500MA;
      else if (sel == 2'h1)
         pin_limit = ucpd_pkg::LIM_EXTERNAL;
      else if (sel == 2'h2)
         pin_limit = ucpd_pkg::LIM_100MA;
      else
         pin_limit = ucpd_pkg::LIM_HIZ;
   endfunction : pin_limit

   ucpd_timer
   #(
      .WIDTH(TW)
   )
   u_dcd_timer
   (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_start(st_reg.tmr_start),
      .i_load(TW'(DCD_CYCLES)),
      .i_stop(st_reg.state != ucpd_pkg::ST_DCD),
      .o_expired(dcd_expired)
   );

   //------------------------------------------------------------
   // next-state logic
   //------------------------------------------------------------
   always_comb
   begin
      logic vbus_rise;
      logic force_req;
      logic [1:0] sel;
      vbus_rise = 1'b0;
      force_req = 1'b0;
      sel = {i_limit_select_hi, i_limit_select_lo};
      st_next = st_reg;
      st_next.tmr_start = 1'b0;
      st_next.vbus_q = i_vbus;
      st_next.sel_q = sel;
      // RULE_01 vbus start only standalone
      vbus_rise = i_vbus && !st_reg.vbus_q && !i_host_mode;
      // RULE_02 host forced run
      force_req = i_wr && i_addr == ucpd_pkg::ADDR_DETECT_CTRL && i_host_mode
                  && i_wdata[ucpd_pkg::BIT_FORCE_DETECT];
      // RULE_16 clear d+ source
      if (i_wr && i_addr == ucpd_pkg::ADDR_DPLUS_CTRL && i_wdata[ucpd_pkg::BIT_CLEAR_DPLUS])
      begin
         st_next.dplus = 1'b0;
      end
      // RULE_04 pins after detection and change
      if (st_reg.done_once && st_reg.state == ucpd_pkg::ST_IDLE && sel != st_reg.sel_q
          && !i_host_mode)
      begin
         st_next.pins_live = 1'b1;
      end
      if (st_reg.pins_live && st_reg.state == ucpd_pkg::ST_IDLE && !i_host_mode)
      begin
         st_next.limit = pin_limit(sel);
         st_next.apply = 1'b1;
      end
      // RULE_05 sequencer: idle plus five detection states
      case (st_reg.state)
         ucpd_pkg::ST_DCD:
         begin
            // RULE_07 contact or timeout
            if (dcd_expired)
               st_next.state = ucpd_pkg::ST_NONSTD;
            else if (i_data_contact)
               st_next.state = ucpd_pkg::ST_PRIMARY;
         end
         ucpd_pkg::ST_PRIMARY:
         begin
            // RULE_08 choose secondary path
            st_next.dcp_path = i_primary_charger;
            st_next.state = ucpd_pkg::ST_SECONDARY;
         end
         ucpd_pkg::ST_SECONDARY:
         begin
            // RULE_10 resolve port type
            if (st_reg.dcp_path)
               st_next.port = i_secondary_dcp ? ucpd_pkg::PT_DCP : ucpd_pkg::PT_CDP;
            else
               st_next.port = i_secondary_nonstd ? ucpd_pkg::PT_NONSTD : ucpd_pkg::PT_SDP;
            st_next.state = ucpd_pkg::ST_CONFIG;
         end
         ucpd_pkg::ST_NONSTD:
         begin
            // RULE_09 pass or retry primary
            if (i_nonstd_pass)
            begin
               st_next.port = ucpd_pkg::PT_NONSTD;
               st_next.state = ucpd_pkg::ST_CONFIG;
            end
            else
               st_next.state = ucpd_pkg::ST_PRIMARY;
         end
         ucpd_pkg::ST_CONFIG:
         begin
            // RULE_11 RULE_12 RULE_18 apply settings
            st_next.limit = limit_of(st_reg.port, i_batt_good);
            // RULE_13 charge timer
            st_next.timer = timer_of(st_reg.port, i_batt_good);
            // RULE_03 no limit in host run
            st_next.apply = !st_reg.host_run;
            // RULE_14 RULE_15 dead battery d+ source
            st_next.dplus = !i_batt_good && (st_reg.port == ucpd_pkg::PT_CDP
                            || st_reg.port == ucpd_pkg::PT_SDP);
            st_next.done_once = 1'b1;
            st_next.pins_live = 1'b0;
            st_next.state = ucpd_pkg::ST_IDLE;
         end
         default:
         begin
            // RULE_19 hold result while idle
            st_next.state = ucpd_pkg::ST_IDLE;
         end
      endcase
      // RULE_06 enter contact detect
      if (vbus_rise || force_req)
      begin
         st_next.state = ucpd_pkg::ST_DCD;
         st_next.host_run = force_req;
         st_next.tmr_start = 1'b1;
         st_next.port = ucpd_pkg::PT_NONE;
      end
      // read data
      st_next.rdata = 8'h00;
      if (i_rd)
      begin
         if (i_addr == ucpd_pkg::ADDR_DETECT_CTRL)
            st_next.rdata = {7'h00, st_reg.state != ucpd_pkg::ST_IDLE};
         else if (i_addr == ucpd_pkg::ADDR_DPLUS_CTRL)
            st_next.rdata = {7'h00, st_reg.dplus};
         else if (i_addr == ucpd_pkg::ADDR_RESULT)
            st_next.rdata = {st_reg.timer, st_reg.limit, st_reg.port};
      end
      // registered busy flag
      st_next.busy = st_next.state != ucpd_pkg::ST_IDLE;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         st_reg <= '0;
         st_reg.limit <= ucpd_pkg::LIM_100MA;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_rdata = st_reg.rdata;
   assign o_dplus_source = st_reg.dplus;
   assign o_current_limit = st_reg.limit;
   assign o_limit_apply = st_reg.apply;
   assign o_charge_timer = st_reg.timer;
   assign o_port_type = st_reg.port;
   assign o_detect_busy = st_reg.busy;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   chk_host_no_apply: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_03
      st_reg.state == ucpd_pkg::ST_CONFIG && st_reg.host_run |=> !o_limit_apply)
      else $error("limit applied after host run");
   chk_force_enters: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_02
      i_wr && i_host_mode && i_addr == ucpd_pkg::ADDR_DETECT_CTRL
      && i_wdata[ucpd_pkg::BIT_FORCE_DETECT] |=> st_reg.state == ucpd_pkg::ST_DCD)
      else $error("forced detect not started");
   chk_vbus_enters: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_06
      $rose(i_vbus) && !i_host_mode |=> st_reg.state == ucpd_pkg::ST_DCD)
      else $error("vbus did not start detect");
   chk_dcd_timeout: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_07
      st_reg.state == ucpd_pkg::ST_DCD && dcd_expired && !i_wr
      && !(i_vbus && !st_reg.vbus_q) |=>
      st_reg.state == ucpd_pkg::ST_NONSTD)
      else $error("timeout did not reach nonstd");
   chk_nonstd_fail: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_09
      st_reg.state == ucpd_pkg::ST_NONSTD && !i_nonstd_pass && !i_wr
      && !(i_vbus && !st_reg.vbus_q) |=>
      st_reg.state == ucpd_pkg::ST_PRIMARY)
      else $error("nonstd fail did not retry");
   chk_cdp_limit: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_12
      st_reg.state == ucpd_pkg::ST_CONFIG && st_reg.port == ucpd_pkg::PT_CDP && i_batt_good
      |=> o_current_limit == ucpd_pkg::LIM_1500MA && o_charge_timer == ucpd_pkg::TMR_6HOUR)
      else $error("cdp settings wrong");
   chk_dead_limit: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_14
      st_reg.state == ucpd_pkg::ST_CONFIG && !i_batt_good && st_reg.port == ucpd_pkg::PT_SDP
      |=> o_current_limit == ucpd_pkg::LIM_100MA && o_dplus_source
      && o_charge_timer == ucpd_pkg::TMR_45MIN)
      else $error("dead battery settings wrong");
   chk_dplus_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_16
      i_wr && i_addr == ucpd_pkg::ADDR_DPLUS_CTRL && i_wdata[ucpd_pkg::BIT_CLEAR_DPLUS]
      && st_reg.state != ucpd_pkg::ST_CONFIG |=> !o_dplus_source)
      else $error("d+ source not cleared");
   chk_secondary_cfg: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RULE_10
      st_reg.state == ucpd_pkg::ST_SECONDARY && !i_wr && !($rose(i_vbus)) ##1 !$rose(i_vbus)
      |-> st_reg.state == ucpd_pkg::ST_CONFIG)
      else $error("secondary did not configure");
endmodule : ucpd_detect
`default_nettype wire

// ---- design/ucpd_pkg.sv ----
// package: constants and types for the usb charge port detector
package ucpd_pkg;
   // register map (word offsets on the plain port)
   localparam logic [7:0] ADDR_DETECT_CTRL = 8'h04;
   localparam logic [7:0] ADDR_DPLUS_CTRL = 8'h07;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam int BIT_FORCE_DETECT = 4;
   localparam int BIT_CLEAR_DPLUS = 4;
   // input current limit codes
   localparam logic [2:0] LIM_100MA = 3'h0;
   localparam logic [2:0] LIM_500MA = 3'h1;
   localparam logic [2:0] LIM_1500MA = 3'h2;
   localparam logic [2:0] LIM_EXTERNAL = 3'h3;
   localparam logic [2:0] LIM_HIZ = 3'h4;
   // charge timer codes
   localparam logic [1:0] TMR_NONE = 2'h0;
   localparam logic [1:0] TMR_45MIN = 2'h1;
   localparam logic [1:0] TMR_6HOUR = 2'h2;
   // data contact detect timeout
   localparam int CLK_HZ = 25_000_000;
   localparam int DCD_TIMEOUT_MS = 600;
   localparam int DCD_TIMEOUT_CYCLES = DCD_TIMEOUT_MS * (CLK_HZ / 1000);
   // port types
   typedef enum logic [2:0]
   {
      PT_NONE = 3'h0,
      PT_DCP = 3'h1,
      PT_CDP = 3'h2,
      PT_SDP = 3'h3,
      PT_NONSTD = 3'h4
   } ucpd_port_type;
   // sequencer states, gray along the usual path
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_DCD = 3'b001,
      ST_PRIMARY = 3'b011,
      ST_SECONDARY = 3'b010,
      ST_CONFIG = 3'b110,
      ST_NONSTD = 3'b111
   } ucpd_state_type;
endpackage : ucpd_pkg

// ---- design/ucpd_timer.sv ----
// module: load-and-count-down timeout counter
`timescale 1ns/1ns
`default_nettype none
module ucpd_timer
#(
   parameter int WIDTH = 25
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_start,
   input wire logic [WIDTH-1:0] i_load,
   input wire logic i_stop,
   // status
   output logic o_expired
);
   typedef struct packed
   {
      logic [WIDTH-1:0] count;
      logic running;
      logic expired;
   } ucpd_tmr_type;
   ucpd_tmr_type tmr_reg;
   ucpd_tmr_type tmr_next;

   always_comb
   begin
      tmr_next = tmr_reg;
      tmr_next.expired = 1'b0;
      if (i_start)
      begin
         tmr_next.count = i_load;
         tmr_next.running = 1'b1;
      end
      else if (i_stop)
      begin
         tmr_next.running = 1'b0;
      end
      else if (tmr_reg.running)
      begin
         if (tmr_reg.count == '0)
         begin
            tmr_next.running = 1'b0;
            tmr_next.expired = 1'b1;
         end
         else
         begin
            tmr_next.count = tmr_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         tmr_reg <= '0;
      end
      else
      begin
         tmr_reg <= tmr_next;
      end
   end

   assign o_expired = tmr_reg.expired;
endmodule : ucpd_timer
`default_nettype wire

// ---- bench/ucpd_port_model.sv ----
// file: behavioural usb source port on the far side of d+/d-
`timescale 1ns/1ns
`default_nettype none
module ucpd_port_model
(
   // port kind and supply
   input wire logic [2:0] i_kind,
   input wire logic i_vbus,
   // comparator levels seen by the detector
   output logic o_data_contact,
   output logic o_primary_charger,
   output logic o_secondary_dcp,
   output logic o_secondary_nonstd,
   output logic o_nonstd_pass
);
   // kinds 5 and 6 never make contact, so the contact timer runs out
   assign o_data_contact = i_vbus && (i_kind < 3'h5);
   assign o_primary_charger = (i_kind == 3'h1) || (i_kind == 3'h2) || (i_kind == 3'h6);
   assign o_secondary_dcp = (i_kind == 3'h1) || (i_kind == 3'h6);
   assign o_secondary_nonstd = (i_kind == 3'h4);
   // kind 5 passes the adapter test, kind 6 fails it
   assign o_nonstd_pass = (i_kind == 3'h5);
endmodule : ucpd_port_model
`default_nettype wire

// ---- bench/tb.sv ----
// file: self-checking bench for the charge port detector
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic i_mclk, i_sys_rst, i_wr, i_rd, i_host_mode, i_vbus, i_batt_good;
   logic [7:0] i_addr, i_wdata, o_rdata, d;
   logic i_limit_select_lo, i_limit_select_hi, o_dplus_source, o_limit_apply, o_detect_busy;
   logic dc, pc, sd, sn, np;
   logic [2:0] port_kind, o_current_limit, o_port_type;
   logic [1:0] o_charge_timer;
   int err_total = 0;
   int tests_run = 0;
   // rows: kind, battery good, limit, timer, port type
   localparam logic [11:0] ROWS [8] = '{
      {3'h1, 1'h1, 3'h3, 2'h2, 3'h1}, {3'h2, 1'h0, 3'h0, 2'h1, 3'h2},
      {3'h2, 1'h1, 3'h2, 2'h2, 3'h2}, {3'h3, 1'h0, 3'h0, 2'h1, 3'h3},
      {3'h3, 1'h1, 3'h4, 2'h0, 3'h3}, {3'h4, 1'h1, 3'h1, 2'h2, 3'h4},
      {3'h5, 1'h1, 3'h1, 2'h2, 3'h4}, {3'h6, 1'h1, 3'h3, 2'h2, 3'h1}};
   // limit by pins {hi, lo}
   localparam logic [2:0] PIN_LIM [4] = '{3'h1, 3'h3, 3'h0, 3'h4};
   // ----------------------------------------
   // instances
   // ----------------------------------------
   ucpd_port_model ucpd_port_model_inst (.i_kind(port_kind), .i_vbus(i_vbus),
      .o_data_contact(dc), .o_primary_charger(pc), .o_secondary_dcp(sd),
      .o_secondary_nonstd(sn), .o_nonstd_pass(np));
   ucpd_detect #(.DCD_CYCLES(20)) ucpd_detect_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_host_mode(i_host_mode), .i_vbus(i_vbus), .i_batt_good(i_batt_good),
      .i_data_contact(dc), .i_primary_charger(pc), .i_secondary_dcp(sd),
      .i_secondary_nonstd(sn), .i_nonstd_pass(np), .i_limit_select_lo(i_limit_select_lo),
      .i_limit_select_hi(i_limit_select_hi), .o_dplus_source(o_dplus_source),
      .o_current_limit(o_current_limit), .o_limit_apply(o_limit_apply),
      .o_charge_timer(o_charge_timer), .o_port_type(o_port_type),
      .o_detect_busy(o_detect_busy));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask : rd
   task automatic wait_done;
      int n;
      n = 0;
      repeat (2) @(posedge i_mclk);
      #1;
      while (o_detect_busy !== 1'b0 && n < 200)
      begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      if (n == 200)
         chk("busy timeout", 8'h00, 8'h01);
      @(posedge i_mclk);
      #1;
   endtask : wait_done
   task automatic attach(input logic [2:0] kind, input logic batt);
      @(posedge i_mclk);
      port_kind <= kind;
      i_batt_good <= batt;
      i_vbus <= 1'b0;
      @(posedge i_mclk);
      i_vbus <= 1'b1;
      wait_done();
   endtask : attach
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   initial
   begin
      #800000;
      err_total++;
      print_verdict();
   end
   initial
   begin
      {i_sys_rst, i_wr, i_rd, i_host_mode, i_vbus, i_batt_good} = 6'h20;
      {i_addr, i_wdata, port_kind, i_limit_select_lo, i_limit_select_hi} = 21'h0;
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      #1;
      chk("reset limit", 8'h00, o_current_limit);
      chk("reset port", 8'h00, o_port_type);
      // pin change before any detection has no effect
      i_limit_select_lo <= 1'b1;
      repeat (3) @(posedge i_mclk);
      #1;
      chk("early pin apply", 8'h00, o_limit_apply);
      rd(8'h3c, d);
      chk("unmapped read", 8'h00, d);
      for (int r = 0; r < 8; r++)
      begin
         attach(ROWS[r][11:9], ROWS[r][8]);
         chk("limit", ROWS[r][7:5], o_current_limit);
         chk("timer", ROWS[r][4:3], o_charge_timer);
         chk("port", ROWS[r][2:0], o_port_type);
         chk("apply", 8'h01, o_limit_apply);
         if (ROWS[r][8] == 1'b0)
            chk("dplus on", 8'h01, o_dplus_source);
      end
      rd(8'h08, d);
      chk("result reg", 8'h99, d);
      port_kind <= 3'h3;
      repeat (5) @(posedge i_mclk);
      #1;
      chk("held port", 8'h01, o_port_type);
      attach(3'h2, 1'b0);
      chk("dead limit", 8'h00, o_current_limit);
      rd(8'h07, d);
      chk("dplus reg", 8'h01, d);
      // clear write drops the d+ source on the edge that ends the write strobe
      wr(8'h07, 8'h10);
      #1;
      chk("dplus off", 8'h00, o_dplus_source);
      rd(8'h07, d);
      chk("dplus reg off", 8'h00, d);
      i_host_mode <= 1'b1;
      attach(3'h1, 1'b1);
      chk("host vbus", 8'h02, o_port_type);
      wr(8'h04, 8'h10);
      rd(8'h04, d);
      chk("busy reg", 8'h01, d);
      chk("busy pin", 8'h01, o_detect_busy);
      wait_done();
      chk("forced port", 8'h01, o_port_type);
      chk("forced apply", 8'h00, o_limit_apply);
      i_host_mode <= 1'b0;
      port_kind <= 3'h3;
      wr(8'h04, 8'h10);
      wait_done();
      chk("refused force", 8'h01, o_port_type);
      for (int p = 0; p < 4; p++)
      begin
         i_limit_select_lo <= p[0];
         i_limit_select_hi <= p[1];
         repeat (3) @(posedge i_mclk);
         #1;
         chk("pin limit", PIN_LIM[p], o_current_limit);
         chk("pin apply", 8'h01, o_limit_apply);
      end
      // reset in mid-run clears results, then power-up detection runs first
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      #1;
      chk("mid reset port", 8'h00, o_port_type);
      chk("mid reset limit", 8'h00, o_current_limit);
      chk("mid reset apply", 8'h00, o_limit_apply);
      chk("mid reset dplus", 8'h00, o_dplus_source);
      chk("mid reset busy", 8'h00, o_detect_busy);
      wait_done();
      chk("power-up port", 8'h03, o_port_type);
      chk("power-up limit", 8'h04, o_current_limit);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
